// ### rtl/rfa_pkg.sv
/*
 Package for reference clock output A: register map, field layout, reset values,
 synthesizer codes, phase increments and loss timing.
 Assumes a 200 MHz system clock and an 8-bit register port with a 10-bit address.
*/
package rfa_pkg;

   // Register port geometry
   localparam int ADDR_W = 10;
   localparam int DATA_W = 8;

   // Register offsets
   localparam logic [9:0] SRC_CTRL_OFS = 10'h240;
   localparam logic [9:0] CONFIG_OFS = 10'h244;

   // Source control fields
   localparam int SRC_EN_BIT = 6;
   localparam int SRC_RATE_BIT = 5;
   localparam int SRC_SEL_MSB = 4;
   localparam logic [7:0] SRC_CTRL_RST = 8'h41;
   localparam logic [7:0] SRC_CTRL_MASK = 8'h7F;

   // Config fields
   localparam int CFG_HOLD_BIT = 5;
   localparam int CFG_BYP_BIT = 4;
   localparam int CFG_FREE_BIT = 3;
   localparam logic [7:0] CONFIG_RST = 8'h00;
   localparam logic [7:0] CONFIG_MASK = 8'h3F;

   // Source select codes
   localparam int NUM_CH = 22;
   localparam int NUM_SRC = 23;
   localparam logic [4:0] LAST_CH_CODE = 5'h15;
   localparam int EXT_IDX = 22;

   // Synthesizer frequency codes
   localparam logic [2:0] FREQ_SAME = 3'h0;
   localparam logic [2:0] FREQ_8K = 3'h1;
   localparam logic [2:0] FREQ_64K = 3'h2;
   localparam logic [2:0] FREQ_RSVD = 3'h3;
   localparam logic [2:0] FREQ_4M096 = 3'h4;
   localparam logic [2:0] FREQ_8M192 = 3'h5;
   localparam logic [2:0] FREQ_19M44 = 3'h6;
   localparam logic [2:0] FREQ_32M768 = 3'h7;

   // Clock rate and phase increments (f / f_clk * 2^32)
   localparam longint CLK_HZ = 64'h0BEB_C200;
   localparam int CLK_PERIOD_NS = 5;
   localparam logic [31:0] INC_1M544 = 32'((64'h0017_8F40 << 32) / CLK_HZ);
   localparam logic [31:0] INC_2M048 = 32'((64'h001F_4000 << 32) / CLK_HZ);
   localparam logic [31:0] INC_8K = 32'((64'h0000_1F40 << 32) / CLK_HZ);
   localparam logic [31:0] INC_64K = 32'((64'h0000_FA00 << 32) / CLK_HZ);
   localparam logic [31:0] INC_4M096 = 32'((64'h003E_8000 << 32) / CLK_HZ);
   localparam logic [31:0] INC_8M192 = 32'((64'h007D_0000 << 32) / CLK_HZ);
   localparam logic [31:0] INC_19M44 = 32'((64'h0128_A180 << 32) / CLK_HZ);
   localparam logic [31:0] INC_32M768 = 32'((64'h01F4_0000 << 32) / CLK_HZ);

   // Loss of source: no edge for this long
   localparam int LOSS_TIME_NS = 2000;
   localparam int LOSS_CYC = LOSS_TIME_NS / CLK_PERIOD_NS;
   localparam int LOSS_W = 10;

   // Config register carrier
   typedef struct packed {
      logic hold_high;
      logic bypass;
      logic free_run;
      logic [2:0] freq;
   } rfa_cfg_s;

   // Output selection
   typedef enum logic [3:0] {
      RFA_OUT_HIGH = 4'h1,
      RFA_OUT_PASS = 4'h2,
      RFA_OUT_NCO = 4'h4,
      RFA_OUT_LINE = 4'h8
   } rfa_out_e;

endpackage

// ### rtl/rfa_loss_mon.sv
/*
 Loss monitor: counts cycles since the last rising edge of the selected,
 already synchronised source and flags loss after LOSS_CYC cycles.
 Assumes its input is glitch free and in the sys_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module rfa_loss_mon
   import rfa_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Monitored level and restart on source change
   input wire logic src_lvl,
   input wire logic restart,
   // Loss flag
   output logic lost
);

   logic prev_lvl;
   logic [LOSS_W-1:0] idle_cnt;

   ////////////////////////////////////////////////////////////////////////////
   // Edge history
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         prev_lvl <= 1'b0;
      else
         prev_lvl <= src_lvl;

   // Idle counter saturates so loss stays asserted while the source is dead
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         idle_cnt <= '0;
      else if (restart || (src_lvl && !prev_lvl))
         idle_cnt <= '0;
      else if (idle_cnt != LOSS_W'(LOSS_CYC))
         idle_cnt <= idle_cnt + 1'b1;

   // Loss flag
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         lost <= 1'b0;
      else
         lost <= (idle_cnt == LOSS_W'(LOSS_CYC)) && !restart;

endmodule
`default_nettype wire

// ### rtl/rfa_nco.sv
/*
 Phase accumulator clock generator; the MSB of the accumulator is the clock.
 Assumes the increment is static for long stretches; jitter is one sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module rfa_nco
   import rfa_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Phase increment per cycle
   input wire logic [31:0] inc,
   // Generated clock level
   output logic clk_out
);

   logic [31:0] phase;

   ////////////////////////////////////////////////////////////////////////////
   // Accumulator wraps naturally
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         phase <= '0;
      else
         phase <= phase + inc;

   assign clk_out = phase[31];

endmodule
`default_nettype wire

// ### rtl/rfa_ref_out.sv
/*
 Reference clock output A: source selection, synthesizer mode, fallback on loss,
 output enable and the two configuration registers.
 Assumes pin clocks are far slower than sys_clk (200 MHz) and that the line
 mode input comes from logic on sys_clk.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Free-run honoured only through the synthesizer
// - Free-run 0: locked clock at programmed rate
// - Free-run 1: free-running clock from master clock
// - External source lost: high or free-run clock
// - Recovered lost, synth on: free-run or high
// - Recovered lost, bypassed: line-rate clock or high
// - Frequency field used only with synthesizer
// - Code 000 locked: source rate passed
// - Codes give 8k to 32.768M; 011 reserved
// - Enable 0 floats output; default driven
// - Rate bit: external input T1 or E1; code feeds it only to a rate never output
// - Source codes pick channel or external
module rfa_ref_out
   import rfa_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // Clock inputs
   input wire logic [NUM_CH-1:0] recovered_line_clock,
   input wire logic ext_clock_a,
   input wire logic line_e1_mode,
   // Reference output pin
   output logic ref_out_a,
   output logic ref_out_a_enable
);

   logic [7:0] ref_a_source_ctrl;
   rfa_cfg_s ref_a_config;
   logic [NUM_SRC-1:0] sync1, sync2, sync3, stable;
   logic [4:0] src_q;
   logic src_changed;
   logic sel_ext;
   logic sel_lvl;
   logic lost;
   logic nco_clk;
   logic [31:0] nco_inc;
   rfa_out_e out_sel;

   ////////////////////////////////////////////////////////////////////////////
   // Decoding

   // Phase increment for a synthesizer code; reserved codes give none
   function automatic logic [31:0] freq_inc(input logic [2:0] code, input logic e1);
      unique case (code)
         FREQ_8K: freq_inc = INC_8K;
         FREQ_64K: freq_inc = INC_64K;
         FREQ_4M096: freq_inc = INC_4M096;
         FREQ_8M192: freq_inc = INC_8M192;
         FREQ_19M44: freq_inc = INC_19M44;
         FREQ_32M768: freq_inc = INC_32M768;
         FREQ_SAME: freq_inc = e1 ? INC_2M048 : INC_1M544;
         FREQ_RSVD: freq_inc = '0;
      endcase
   endfunction

   // Register address match
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] ofs);
      hit = (a == ofs);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   // Source control register
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         ref_a_source_ctrl <= SRC_CTRL_RST;
      else if (reg_wr && hit(reg_addr, SRC_CTRL_OFS))
         ref_a_source_ctrl <= reg_wdata & SRC_CTRL_MASK;

   // Synthesizer config register
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         ref_a_config <= rfa_cfg_s'(CONFIG_RST[5:0]);
      else if (reg_wr && hit(reg_addr, CONFIG_OFS))
         ref_a_config <= rfa_cfg_s'(reg_wdata[5:0]);

   // Read data one cycle after the strobe; unmapped and idle read zero
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         reg_rdata <= '0;
      else if (reg_rd && hit(reg_addr, SRC_CTRL_OFS))
         reg_rdata <= ref_a_source_ctrl;
      else if (reg_rd && hit(reg_addr, CONFIG_OFS))
         reg_rdata <= {2'h0, ref_a_config};
      else
         reg_rdata <= '0;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: a change counts once stages two and three agree
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
      begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end
      else
      begin
         sync1 <= {ext_clock_a, recovered_line_clock};
         sync2 <= sync1;
         sync3 <= sync2;
      end

   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         stable <= '0;
      else
         stable <= (sync2 & sync3) | (stable & (sync2 | sync3));

   ////////////////////////////////////////////////////////////////////////////
   // Source selection
   // channel or external code
   assign sel_ext = ref_a_source_ctrl[SRC_SEL_MSB:0] > LAST_CH_CODE;
   assign sel_lvl = sel_ext ? stable[EXT_IDX] : stable[ref_a_source_ctrl[SRC_SEL_MSB:0]];

   // Restart loss monitor when the selection moves, avoiding a false loss
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         src_q <= SRC_CTRL_RST[SRC_SEL_MSB:0];
      else
         src_q <= ref_a_source_ctrl[SRC_SEL_MSB:0];

   assign src_changed = src_q != ref_a_source_ctrl[SRC_SEL_MSB:0];

   rfa_loss_mon u_loss
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .src_lvl(sel_lvl),
      .restart(src_changed),
      .lost(lost)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Generator rate: line rate for bypassed fallback, else the field
   always_comb
   begin
      nco_inc = freq_inc(ref_a_config.freq, 1'b0);
      if (out_sel == RFA_OUT_LINE)
         nco_inc = line_e1_mode ? INC_2M048 : INC_1M544;
      else if (ref_a_config.freq == FREQ_SAME)
         nco_inc = freq_inc(FREQ_SAME, sel_ext ? ref_a_source_ctrl[SRC_RATE_BIT] : line_e1_mode);
   end

   rfa_nco u_nco
   (
      .sys_clk(sys_clk),
      .rst(rst),
      .inc(nco_inc),
      .clk_out(nco_clk)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Output mode decision
   always_comb
   begin
      out_sel = RFA_OUT_HIGH;
      if (ref_a_config.bypass)
      begin
         if (!lost)
            out_sel = RFA_OUT_PASS;
         else if (sel_ext)
            out_sel = RFA_OUT_HIGH;
         else if (!ref_a_config.hold_high)
            out_sel = RFA_OUT_LINE;
      end
      else if (ref_a_config.free_run)
      begin
         // code 000 and 011 undefined here
         if (ref_a_config.freq != FREQ_SAME && ref_a_config.freq != FREQ_RSVD)
            out_sel = RFA_OUT_NCO;
      end
      else if (!lost)
      begin
         if (ref_a_config.freq == FREQ_SAME)
            out_sel = RFA_OUT_PASS;
         else if (ref_a_config.freq != FREQ_RSVD)
            out_sel = RFA_OUT_NCO;
      end
      else if (!sel_ext && !ref_a_config.hold_high && ref_a_config.freq != FREQ_RSVD)
         out_sel = RFA_OUT_NCO;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output pin registers
   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         ref_out_a <= 1'b1;
      else
      begin
         unique case (out_sel)
            RFA_OUT_HIGH: ref_out_a <= 1'b1;
            RFA_OUT_PASS: ref_out_a <= sel_lvl;
            RFA_OUT_NCO: ref_out_a <= nco_clk;
            RFA_OUT_LINE: ref_out_a <= nco_clk;
         endcase
      end

   always_ff @(posedge sys_clk or posedge rst)
      if (rst)
         ref_out_a_enable <= SRC_CTRL_RST[SRC_EN_BIT];
      else
         ref_out_a_enable <= ref_a_source_ctrl[SRC_EN_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   a_oe_off_write: assert property (@(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == SRC_CTRL_OFS && !reg_wdata[SRC_EN_BIT] |-> ##2 !ref_out_a_enable)
      else $error("output enable not cleared after write");

   a_ext_lost_high: assert property (@(posedge sys_clk) disable iff (rst)
      sel_ext && lost && (ref_a_config.bypass || !ref_a_config.free_run) |=> ref_out_a)
      else $error("lost external source did not drive high");

   a_hold_high: assert property (@(posedge sys_clk) disable iff (rst)
      !sel_ext && lost && !ref_a_config.free_run && ref_a_config.hold_high |=> ref_out_a)
      else $error("holdover high not applied");

   a_code_zero_pass: assert property (@(posedge sys_clk) disable iff (rst)
      !rst && !lost && !ref_a_config.bypass && !ref_a_config.free_run
      && ref_a_config.freq == FREQ_SAME |=> ref_out_a == $past(sel_lvl))
      else $error("code 000 did not pass source");

   a_bypass_pass: assert property (@(posedge sys_clk) disable iff (rst)
      !lost && ref_a_config.bypass |=> ref_out_a == $past(sel_lvl))
      else $error("bypass did not pass source");

   a_free_run_nco: assert property (@(posedge sys_clk) disable iff (rst)
      !ref_a_config.bypass && ref_a_config.free_run && ref_a_config.freq == FREQ_32M768
      |=> ref_out_a == $past(nco_clk))
      else $error("free-run clock not from generator");

   a_line_rate: assert property (@(posedge sys_clk) disable iff (rst)
      ref_a_config.bypass && lost && !sel_ext && !ref_a_config.hold_high
      |-> nco_inc == (line_e1_mode ? INC_2M048 : INC_1M544))
      else $error("bypassed fallback rate wrong");

   a_ext_select: assert property (@(posedge sys_clk) disable iff (rst)
      ref_a_source_ctrl[SRC_SEL_MSB:0] >= 5'h16 |-> sel_lvl == stable[EXT_IDX])
      else $error("high source code not external");

   a_read_source: assert property (@(posedge sys_clk) disable iff (rst)
      reg_rd && reg_addr == SRC_CTRL_OFS |=> reg_rdata == $past(ref_a_source_ctrl))
      else $error("source register read back wrong");

   a_oe_on_write: assert property (@(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == SRC_CTRL_OFS && reg_wdata[SRC_EN_BIT] |-> ##2 ref_out_a_enable)
      else $error("output enable not set after write");

   a_read_config: assert property (@(posedge sys_clk) disable iff (rst)
      reg_rd && reg_addr == CONFIG_OFS
      |=> reg_rdata[7:6] == 2'h0 && reg_rdata[5:0] == $past(ref_a_config))
      else $error("config register read back wrong");

   a_free_ignored: assert property (@(posedge sys_clk) disable iff (rst)
      ref_a_config.bypass && ref_a_config.free_run && !lost |=> ref_out_a == $past(sel_lvl))
      else $error("free-run honoured while bypassed");

   a_lock_nco: assert property (@(posedge sys_clk) disable iff (rst)
      !ref_a_config.bypass && !ref_a_config.free_run && !lost
      && ref_a_config.freq == FREQ_4M096 |=> ref_out_a == $past(nco_clk))
      else $error("locked clock not from generator");

   a_lost_free_clk: assert property (@(posedge sys_clk) disable iff (rst)
      !ref_a_config.bypass && !sel_ext && lost && !ref_a_config.hold_high
      && ref_a_config.freq == FREQ_4M096 |=> ref_out_a == $past(nco_clk))
      else $error("lost recovered source not free running");

   a_ext_free_run: assert property (@(posedge sys_clk) disable iff (rst)
      !ref_a_config.bypass && ref_a_config.free_run && sel_ext && lost
      && ref_a_config.freq == FREQ_4M096 |=> ref_out_a == $past(nco_clk))
      else $error("lost external source not free running");

endmodule
`default_nettype wire

// ### dv/rfa_sink.sv
/*
 Downstream sink for reference clock A: counts rising edges of the pin while armed.
 Assumes the bench resolves the pin to z while the output is disabled.
*/
`timescale 1ns/1ps
`default_nettype none
module rfa_sink
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Resolved pin and count gate
   input wire logic pin,
   input wire logic arm,
   // Edges seen while armed
   output logic [15:0] edges
);
   ////////////////////////////////////////////////////////////////////////////////
   logic last;

   // A floating pin never counts, so a disabled output reads as no clock
   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         last <= 1'b1;
         edges <= 16'h0000;
      end
      else
      begin
         last <= pin;
         if (!arm)
            edges <= 16'h0000;
         else if (last === 1'b0 && pin === 1'b1)
            edges <= edges + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ### dv/rfa_ref_out_tb.sv
/*
 Bench for reference clock output A: register port tasks and edge counts per mode.
 Assumes the output settles within SETTLE cycles of a change or a source stop.
*/
`timescale 1ns/1ps
`default_nettype none
module rfa_ref_out_tb
   import rfa_pkg::*;
;
   ////////////////////////////////////////////////////////////////////////////////
   localparam int WIN = 3240;
   localparam int SETTLE = 500;
   localparam real F_REC = 1.0e9 / 648.0;
   localparam real F_EXT = 1.0e9 / 362.0;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] reg_addr = 10'h000;
   logic [DATA_W-1:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic [NUM_CH-1:0] recovered_line_clock;
   logic ext_clock_a;
   logic line_e1_mode = 1'b0;
   logic ref_out_a;
   logic ref_out_a_enable;
   logic rec_clk = 1'b0;
   logic ext_clk = 1'b0;
   logic [NUM_CH-1:0] line_mask = 22'h000000;
   logic ext_alive = 1'b0;
   logic arm = 1'b0;
   logic [15:0] edges;
   logic [7:0] rd;
   wire pin_wire;
   int mismatches = 0;
   int n_tests = 0;
   logic [2:0] fcode [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
   real fhz [6] = '{8.0e3, 64.0e3, 4.096e6, 8.192e6, 19.44e6, 32.768e6};

   // Clocks; source periods are not whole multiples of the sys_clk period so they drift against sys_clk
   always #2.5 sys_clk = ~sys_clk;
   always #324 rec_clk = ~rec_clk;
   always #181 ext_clk = ~ext_clk;

   // Stopped sources rest low; only the selected channel runs
   assign recovered_line_clock = {NUM_CH{rec_clk}} & line_mask;
   assign ext_clock_a = ext_clk & ext_alive;
   assign pin_wire = ref_out_a_enable ? ref_out_a : 1'bz;

   rfa_ref_out rfa_ref_out_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .recovered_line_clock(recovered_line_clock), .ext_clock_a(ext_clock_a),
      .line_e1_mode(line_e1_mode), .ref_out_a(ref_out_a), .ref_out_a_enable(ref_out_a_enable));
   rfa_sink rfa_sink_inst (.sys_clk(sys_clk), .rst(rst), .pin(pin_wire), .arm(arm),
      .edges(edges));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Edge counts get one edge of slack for window phase
   task automatic chk_edges(input string what, input int exp, input logic [15:0] got);
      n_tests++;
      if ($isunknown(got) || int'(got) < exp - 1 || int'(got) > exp + 1)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask

   // Configure, let loss detection and sync settle, then count pin edges
   task automatic run_case(input string what, input logic [7:0] src, input logic [7:0] cfg,
      input logic e1, input logic alive, input real hz);
      int exp;
      exp = $rtoi(hz * WIN * 5.0e-9 + 0.5);
      reg_write(SRC_CTRL_OFS, src);
      line_mask <= (alive && src[4:0] <= LAST_CH_CODE) ? 22'h000001 << src[4:0] : 22'h000000;
      ext_alive <= alive && src[4:0] > LAST_CH_CODE;
      line_e1_mode <= e1;
      reg_write(CONFIG_OFS, cfg);
      repeat (SETTLE) @(posedge sys_clk);
      arm <= 1'b1;
      repeat (WIN) @(posedge sys_clk);
      arm <= 1'b0;
      @(negedge sys_clk);
      chk_edges(what, exp, edges);
      if (hz == 0.0 && src[6])
         chk_byte({what, " level"}, 8'h01, {7'h00, ref_out_a});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Hang guard, past the roughly 431 us the cases take yet under 100k cycles
   initial
   begin
      #480000;
      mismatches++;
      finish_test();
   end

   // Main sequence
   initial
   begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      chk_byte("enable at reset", 8'h01, {7'h00, ref_out_a_enable});
      reg_read(SRC_CTRL_OFS, rd);
      chk_byte("source reset", 8'h41, rd);
      reg_read(CONFIG_OFS, rd);
      chk_byte("config reset", 8'h00, rd);
      reg_write(10'h300, 8'hFF);
      reg_read(10'h300, rd);
      chk_byte("unmapped read", 8'h00, rd);
      reg_write(SRC_CTRL_OFS, 8'hFF);
      reg_read(SRC_CTRL_OFS, rd);
      chk_byte("source rw", 8'h7F, rd);
      reg_write(CONFIG_OFS, 8'hFF);
      reg_read(CONFIG_OFS, rd);
      chk_byte("config rw", 8'h3F, rd);
      run_case("disabled", 8'h01, 8'h10, 1'b0, 1'b1, 0.0);
      chk_byte("enable off", 8'h00, {7'h00, ref_out_a_enable});
      run_case("bypass free", 8'h41, 8'h1F, 1'b0, 1'b1, F_REC);
      run_case("locked same", 8'h41, 8'h00, 1'b0, 1'b1, F_REC);
      run_case("locked 4M", 8'h41, 8'h04, 1'b0, 1'b1, 4.096e6);
      for (int i = 0; i < 6; i++)
         run_case("free sweep", 8'h41, {5'h01, fcode[i]}, 1'b0, 1'b1, fhz[i]);
      run_case("channel 0", 8'h40, 8'h10, 1'b0, 1'b1, F_REC);
      run_case("channel 21", 8'h55, 8'h10, 1'b0, 1'b1, F_REC);
      run_case("external", 8'h77, 8'h10, 1'b0, 1'b1, F_EXT);
      run_case("code 1F", 8'h5F, 8'h10, 1'b0, 1'b1, F_EXT);
      run_case("lost byp T1", 8'h43, 8'h10, 1'b0, 1'b0, 1.544e6);
      run_case("lost byp E1", 8'h43, 8'h10, 1'b1, 1'b0, 2.048e6);
      run_case("lost byp hold", 8'h43, 8'h30, 1'b0, 1'b0, 0.0);
      run_case("lost free", 8'h43, 8'h0C, 1'b0, 1'b0, 4.096e6);
      run_case("lost lock", 8'h43, 8'h04, 1'b0, 1'b0, 4.096e6);
      run_case("lost hold", 8'h43, 8'h24, 1'b0, 1'b0, 0.0);
      run_case("ext lost byp", 8'h57, 8'h1C, 1'b0, 1'b0, 0.0);
      run_case("ext lost lock", 8'h57, 8'h04, 1'b0, 1'b0, 0.0);
      run_case("ext lost free", 8'h57, 8'h2C, 1'b0, 1'b0, 4.096e6);
      finish_test();
   end
endmodule
`default_nettype wire
